//--- rtl/pmc_pkg.sv
package pmc_pkg;

    // Register byte offsets on the APB
    localparam logic [7:0] OFS_PCTRL_A = 8'h00;
    localparam logic [7:0] OFS_PCTRL_B = 8'h04;
    localparam logic [7:0] OFS_REG_CTRL = 8'h08;
    localparam logic [7:0] OFS_CLK_SEL = 8'h0c;
    localparam logic [7:0] OFS_MODE = 8'h10;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h18;

    // Field positions
    localparam int BIT_IDLE = 0;
    localparam int BIT_STOP = 1;
    localparam int BIT_SUSPEND = 0;
    localparam int BIT_SNOOZE = 1;
    localparam int BIT_STOP_SEL = 0;
    localparam int SRC_LSB = 0;
    localparam int DIV_LSB = 4;
    localparam int BIT_PRE15 = 8;

    // Clock source codes
    localparam logic [2:0] SRC_FAST24 = 3'h0;
    localparam logic [2:0] SRC_FAST49 = 3'h1;
    localparam logic [2:0] SRC_SLOW80 = 3'h2;
    localparam logic [2:0] SRC_EXT_RC = 3'h3;
    localparam logic [2:0] SRC_EXT_CMOS = 3'h4;
    localparam int NUM_SRC = 5;

    // Values after reset: fast 24 MHz source divided by 8
    localparam logic [2:0] SRC_RESET = SRC_FAST24;
    localparam logic [2:0] DIV_RESET = 3'h3;
    localparam logic PRE_RESET = 1'b0;
    localparam logic STOP_SEL_RESET = 1'b0;

    // 1.5x prescaler passes two of every three source ticks
    localparam logic [1:0] PRE_LAST = 2'h2;

    // Interrupt status bits
    localparam int IRQ_IDLE_WAKE = 0;
    localparam int IRQ_SLEEP_WAKE = 1;
    localparam int IRQ_W = 2;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 2'h0;

    // Asynchronous pin indices in the synchroniser bank
    localparam int PIN_FAST24 = 0;
    localparam int PIN_FAST49 = 1;
    localparam int PIN_SLOW80 = 2;
    localparam int PIN_EXT_RC = 3;
    localparam int PIN_EXT_CMOS = 4;
    localparam int PIN_RST_N = 5;
    localparam int PIN_POR_N = 6;
    localparam int NUM_PIN = 7;
    localparam logic [NUM_PIN-1:0] PIN_RESET = 7'h60;

    typedef enum logic [2:0] {
        ST_RUN,
        ST_IDLE,
        ST_SUSPEND,
        ST_SNOOZE,
        ST_STOP,
        ST_SHUTDOWN
    } pmc_state_t;

endpackage

//--- rtl/pmc_clk_if.sv
`timescale 1ns/1ps
`default_nettype none

interface pmc_clk_if;
    logic [2:0] src;
    logic [2:0] div;
    logic pre15;
    logic [4:0] src_tick;
    logic tick;

    modport ctrl(output src, output div, output pre15, output src_tick, input tick);
    modport divider(input src, input div, input pre15, input src_tick, output tick);
endinterface

`default_nettype wire

//--- rtl/pmc_clk_div.sv
`timescale 1ns/1ps
`default_nettype none

module pmc_clk_div (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    pmc_clk_if.divider ck
);
    import pmc_pkg::*;

    logic [1:0] pre_reg;
    logic [1:0] pre_next;
    logic [6:0] cnt_reg;
    logic [6:0] cnt_next;
    logic tick_reg;
    logic tick_next;
    logic raw;
    logic fast;
    logic pass;
    logic [7:0] lim;

    // Source pick, prescale, then power-of-two divide
    always_comb begin
        raw = (ck.src < 3'(NUM_SRC)) ? ck.src_tick[ck.src] : 1'b0;
        fast = (ck.src == SRC_FAST24) || (ck.src == SRC_FAST49);
        pass = raw;
        pre_next = pre_reg;
        if (raw && fast && ck.pre15) begin
            // Drop every third tick to divide by 1.5
            pass = (pre_reg != PRE_LAST);
            pre_next = (pre_reg == PRE_LAST) ? 2'h0 : pre_reg + 2'h1;
        end
        lim = (8'h01 << ck.div) - 8'h01;
        cnt_next = cnt_reg;
        tick_next = 1'b0;
        if (pass) begin
            if (cnt_reg >= lim[6:0]) begin
                cnt_next = 7'h00;
                tick_next = 1'b1;
            end else begin
                cnt_next = cnt_reg + 7'h01;
            end
        end
    end

    // Register stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_reg <= 2'h0;
            cnt_reg <= 7'h00;
            tick_reg <= 1'b0;
        end else if (ce) begin
            pre_reg <= pre_next;
            cnt_reg <= cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign ck.tick = tick_reg;

endmodule

`default_nettype wire

//--- rtl/pmc_top.sv
// Operation
// - Idle bit halts core, peripherals stay clocked; any interrupt resumes core.
// - Suspend and snooze stop core, peripheral clocks and both fast oscillators.
// - Suspend keeps regulator at normal bias for fast wake.
// - Timers three and four keep slow oscillator clock in suspend and snooze.
// - Six peripheral events wake from suspend or snooze; code continues.
// - Select clear plus stop bit enters stop; nets off, pins held, any reset exits.
// - Select set plus stop bit enters shutdown; only pin or power-on reset exits.
// - After reset system clock is 24 MHz oscillator divided by 8.
// - Divider offers divide by 1, 2, 4, 8, 16, 32, 64, 128.
// - Both fast oscillator paths have optional 1.5x prescaler before divider.
// - Sources: 24 MHz, 49 MHz, 80 kHz, external RC, external CMOS clock.
`timescale 1ns/1ps
`default_nettype none

module pmc_top (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic fast_osc_24m,
    input wire logic fast_osc_49m,
    input wire logic slow_osc_80k,
    input wire logic ext_rc_osc,
    input wire logic ext_cmos_clock,
    input wire logic reset_pin_n,
    input wire logic por_n,
    input wire logic other_rst_req,
    input wire logic irq_any,
    input wire logic timer4_evt,
    input wire logic serial_periph_port_act,
    input wire logic two_wire_target_port_act,
    input wire logic port_match_evt,
    input wire logic comp0_level,
    input wire logic config_logic_unit_evt,
    output logic core_clk_en,
    output logic periph_clk_en,
    output logic tmr34_slow_clk_en,
    output logic fast_osc_24m_en,
    output logic fast_osc_49m_en,
    output logic reg_low_bias,
    output logic power_nets_off,
    output logic pin_hold,
    output logic system_clk_tick,
    output logic irq
);
    import pmc_pkg::*;

    pmc_clk_if ck();

    logic [NUM_PIN-1:0] sync1_reg;
    logic [NUM_PIN-1:0] sync2_reg;
    logic [NUM_PIN-1:0] sync3_reg;
    logic comp0_prev_reg;
    logic [NUM_SRC-1:0] osc_tick;
    logic slow_tick;
    logic rst_any, rst_hard, reinit;
    logic wake_any;

    logic apb_done;
    logic hit_a, hit_b, hit_reg, hit_clk, hit_stat, hit_mask;
    logic mapped;
    logic wr_a, wr_b;
    logic pready_reg;
    logic pready_next;
    logic pslverr_reg;
    logic pslverr_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;

    logic stop_sel_reg;
    logic stop_sel_next;
    logic [2:0] src_reg;
    logic [2:0] src_next;
    logic [2:0] div_reg;
    logic [2:0] div_next;
    logic pre_reg;
    logic pre_next;
    logic [IRQ_W-1:0] mask_reg;
    logic [IRQ_W-1:0] mask_next;

    pmc_state_t state_reg;
    pmc_state_t state_next;
    logic wake_pend_reg, wake_pend_next;
    logic [IRQ_W-1:0] stat_reg;
    logic [IRQ_W-1:0] stat_next;
    logic [IRQ_W-1:0] evt;
    logic [9:0] out_reg;
    logic [9:0] out_next;

    // Two-stage synchronisers for pins, third stage only for edge finding
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg <= PIN_RESET;
            sync2_reg <= PIN_RESET;
            sync3_reg <= PIN_RESET;
            comp0_prev_reg <= 1'b0;
        end else if (ce) begin
            sync1_reg <= {por_n, reset_pin_n, ext_cmos_clock, ext_rc_osc,
                          slow_osc_80k, fast_osc_49m, fast_osc_24m};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            comp0_prev_reg <= comp0_level;
        end
    end

    // Rising edges of each oscillator; sources above half of clk alias
    assign osc_tick = sync2_reg[NUM_SRC-1:0] & ~sync3_reg[NUM_SRC-1:0];
    assign slow_tick = osc_tick[PIN_SLOW80];
    assign rst_hard = !sync2_reg[PIN_RST_N] || !sync2_reg[PIN_POR_N];
    assign rst_any = rst_hard || other_rst_req;
    // Shutdown ignores every reset but the pin and power-on
    assign reinit = rst_hard || (rst_any && state_reg != ST_SHUTDOWN);

    // OR of all sleep wake sources, comparator taken on its falling edge
    assign wake_any = timer4_evt || serial_periph_port_act || two_wire_target_port_act
                      || port_match_evt || config_logic_unit_evt
                      || (comp0_prev_reg && !comp0_level);

    // APB decode; one wait state so read data comes from a flop
    assign apb_done = psel && penable && pready_reg;
    assign hit_a = (paddr == OFS_PCTRL_A);
    assign hit_b = (paddr == OFS_PCTRL_B);
    assign hit_reg = (paddr == OFS_REG_CTRL);
    assign hit_clk = (paddr == OFS_CLK_SEL);
    assign hit_stat = (paddr == OFS_IRQ_STAT);
    assign hit_mask = (paddr == OFS_IRQ_MASK);
    assign mapped = hit_a || hit_b || hit_reg || hit_clk || hit_stat || hit_mask
                    || (paddr == OFS_MODE);
    assign wr_a = apb_done && pwrite && hit_a;
    assign wr_b = apb_done && pwrite && hit_b;

    // APB answer path
    always_comb begin
        pready_next = psel && penable && !pready_reg;
        pslverr_next = psel && penable && !pready_reg && !mapped;
        prdata_next = prdata_reg;
        if (psel && penable && !pready_reg && !pwrite) begin
            prdata_next = 32'h0000_0000;
            if (hit_a) begin
                prdata_next[BIT_IDLE] = (state_reg == ST_IDLE);
            end
            if (hit_b) begin
                prdata_next[BIT_SUSPEND] = (state_reg == ST_SUSPEND);
                prdata_next[BIT_SNOOZE] = (state_reg == ST_SNOOZE);
            end
            if (hit_reg) begin
                prdata_next[BIT_STOP_SEL] = stop_sel_reg;
            end
            if (hit_clk) begin
                prdata_next[SRC_LSB +: 3] = src_reg;
                prdata_next[DIV_LSB +: 3] = div_reg;
                prdata_next[BIT_PRE15] = pre_reg;
            end
            if (paddr == OFS_MODE) begin
                prdata_next[2:0] = state_reg;
            end
            if (hit_stat) begin
                prdata_next[IRQ_W-1:0] = stat_reg;
            end
            if (hit_mask) begin
                prdata_next[IRQ_W-1:0] = mask_reg;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else if (ce) begin
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            prdata_reg <= prdata_next;
        end
    end

    // Software settings; a reset that ends stop restores defaults
    always_comb begin
        stop_sel_next = stop_sel_reg;
        src_next = src_reg;
        div_next = div_reg;
        pre_next = pre_reg;
        mask_next = mask_reg;
        if (reinit) begin
            stop_sel_next = STOP_SEL_RESET;
            src_next = SRC_RESET;
            div_next = DIV_RESET;
            pre_next = PRE_RESET;
            mask_next = IRQ_MASK_RESET;
        end else if (apb_done && pwrite) begin
            if (hit_reg) begin
                stop_sel_next = pwdata[BIT_STOP_SEL];
            end
            if (hit_clk) begin
                src_next = pwdata[SRC_LSB +: 3];
                div_next = pwdata[DIV_LSB +: 3];
                pre_next = pwdata[BIT_PRE15];
            end
            if (hit_mask) begin
                mask_next = pwdata[IRQ_W-1:0];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stop_sel_reg <= STOP_SEL_RESET;
            src_reg <= SRC_RESET;
            div_reg <= DIV_RESET;
            pre_reg <= PRE_RESET;
            mask_reg <= IRQ_MASK_RESET;
        end else if (ce) begin
            stop_sel_reg <= stop_sel_next;
            src_reg <= src_next;
            div_reg <= div_next;
            pre_reg <= pre_next;
            mask_reg <= mask_next;
        end
    end

    // Power mode sequencer with wake events and sticky status
    always_comb begin
        state_next = state_reg;
        wake_pend_next = wake_pend_reg;
        evt = '0;
        unique case (state_reg)
            ST_RUN: begin
                if (wr_a && pwdata[BIT_STOP]) begin
                    // Select bit chooses the deeper of the two
                    state_next = stop_sel_reg ? ST_SHUTDOWN : ST_STOP;
                end else if (wr_a && pwdata[BIT_IDLE]) begin
                    state_next = ST_IDLE;
                end else if (wr_b && pwdata[BIT_SUSPEND]) begin
                    // Clock switch beforehand is left to firmware
                    state_next = ST_SUSPEND;
                end else if (wr_b && pwdata[BIT_SNOOZE]) begin
                    state_next = ST_SNOOZE;
                end
                wake_pend_next = 1'b0;
            end
            ST_IDLE: begin
                if (irq_any) begin
                    state_next = ST_RUN;
                    evt[IRQ_IDLE_WAKE] = 1'b1;
                end
            end
            ST_SUSPEND, ST_SNOOZE: begin
                // Wait for a slow edge so the restart is slow-clock aligned
                if (wake_any) begin
                    wake_pend_next = 1'b1;
                end
                if ((wake_pend_reg || wake_any) && slow_tick) begin
                    state_next = ST_RUN;
                    wake_pend_next = 1'b0;
                    evt[IRQ_SLEEP_WAKE] = 1'b1;
                end
            end
            ST_STOP, ST_SHUTDOWN: begin
                state_next = state_reg;
            end
            default: begin
                state_next = ST_RUN;
            end
        endcase
        if (reinit) begin
            state_next = ST_RUN;
            wake_pend_next = 1'b0;
        end
        // New event beats the read clear
        stat_next = stat_reg;
        if (apb_done && !pwrite && hit_stat) begin
            stat_next = '0;
        end
        stat_next = stat_next | evt;
        // Outputs decoded from the next state so each leaves a flop
        out_next[0] = (state_next == ST_RUN);
        out_next[1] = (state_next == ST_RUN) || (state_next == ST_IDLE);
        out_next[2] = (state_next != ST_STOP) && (state_next != ST_SHUTDOWN);
        out_next[3] = out_next[1];
        out_next[4] = out_next[1] && (src_next == SRC_FAST49);
        out_next[5] = (state_next == ST_SNOOZE);
        out_next[6] = (state_next == ST_STOP) || (state_next == ST_SHUTDOWN);
        out_next[7] = out_next[6];
        out_next[8] = ck.tick && out_next[1];
        out_next[9] = |(stat_next & mask_next);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_RUN;
            wake_pend_reg <= 1'b0;
            stat_reg <= '0;
            out_reg <= 10'h00f; // Fast 49 off, 24 MHz is the reset source
        end else if (ce) begin
            state_reg <= state_next;
            wake_pend_reg <= wake_pend_next;
            stat_reg <= stat_next;
            out_reg <= out_next;
        end
    end

    // Divider sees the live selection and oscillator ticks
    assign ck.src = src_reg;
    assign ck.div = div_reg;
    assign ck.pre15 = pre_reg;
    assign ck.src_tick = osc_tick;

    pmc_clk_div u_div (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .ck(ck)
    );

    // Every output leaves a flop; gate bits packed in out_reg order
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign {irq, system_clk_tick, pin_hold, power_nets_off, reg_low_bias, fast_osc_49m_en,
            fast_osc_24m_en, tmr34_slow_clk_en, periph_clk_en, core_clk_en} = out_reg;

endmodule

`default_nettype wire

//--- test/pmc_top_props.sv
`timescale 1ns/1ps
`default_nettype none

module pmc_top_props (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic irq_any,
    input wire logic timer4_evt,
    input wire logic core_clk_en,
    input wire logic periph_clk_en,
    input wire logic tmr34_slow_clk_en,
    input wire logic fast_osc_24m_en,
    input wire logic fast_osc_49m_en,
    input wire logic reg_low_bias,
    input wire logic power_nets_off,
    input wire logic pin_hold
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Starts of multi-step behaviours
    sequence s_access;
        psel && $rose(penable);
    endsequence
    sequence s_idle_irq;
        periph_clk_en && !core_clk_en && irq_any;
    endsequence
    sequence s_sleep_evt;
        !periph_clk_en && tmr34_slow_clk_en && timer4_evt;
    endsequence

    // Bus answer: one wait cycle, single-cycle strobes
    apb_one_wait_a: assert property (s_access |-> !pready ##1 pready)
        else $error("pready not after one wait");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    // Clock gating per mode
    core_needs_periph_a: assert property (core_clk_en |-> periph_clk_en)
        else $error("core clocked without peripherals");
    fast24_track_a: assert property (fast_osc_24m_en == periph_clk_en)
        else $error("fast 24 enable wrong");
    fast49_gate_a: assert property (fast_osc_49m_en |-> periph_clk_en)
        else $error("fast 49 runs while asleep");
    low_bias_a: assert property (reg_low_bias |-> !periph_clk_en && tmr34_slow_clk_en)
        else $error("low bias outside snooze");
    timers_run_a: assert property (!periph_clk_en && !power_nets_off |-> tmr34_slow_clk_en)
        else $error("timer clock lost in sleep");
    nets_pins_a: assert property (pin_hold == power_nets_off)
        else $error("pin hold differs from nets off");
    nets_off_clocks_a: assert property (power_nets_off |-> !tmr34_slow_clk_en && !periph_clk_en)
        else $error("clocks alive with nets off");
    // Wake-up latency
    idle_wake_a: assert property (s_idle_irq |-> ##[1:2] core_clk_en)
        else $error("idle not left on interrupt");
    sleep_wake_a: assert property (s_sleep_evt |-> ##[1:24] periph_clk_en)
        else $error("sleep not left on wake event");
endmodule

bind pmc_top pmc_top_props u_pmc_top_props (.clk, .rst_n, .psel, .penable, .pready, .pslverr,
    .irq_any, .timer4_evt, .core_clk_en, .periph_clk_en, .tmr34_slow_clk_en, .fast_osc_24m_en,
    .fast_osc_49m_en, .reg_low_bias, .power_nets_off, .pin_hold);

`default_nettype wire

//--- test/pmc_far_end.sv
`timescale 1ns/1ps
`default_nettype none

module pmc_far_end (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic fire,
    input wire logic [2:0] sel,
    input wire logic [1:0] osc_en,
    output logic [4:0] osc,
    output logic [5:0] evt
);
    logic [6:0] cnt_reg;
    logic [6:0] cnt_next;

    // Phase count over 120, a multiple of every period, so no glitch at wrap
    always_comb begin
        cnt_next = (cnt_reg == 7'h77) ? 7'h00 : cnt_reg + 7'h01;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 7'h00;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    // Periods 4 + 2i clocks; fast ones stop when disabled, as real oscillators do
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            osc[i] = ((cnt_reg % (4 + 2 * i)) < (2 + i)) && (i > 1 || osc_en[i % 2]);
        end
    end

    // One-cycle events; comparator idles high so firing it is a falling edge
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            evt[i] = (fire && sel == 3'(i)) ^ (i == 4);
        end
    end
endmodule

`default_nettype wire

//--- test/pmc_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
    $display("Error %s expected %0h seen %0h", nm, e, g); end end

module pmc_top_tb_top;
    import pmc_pkg::*;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic ce = 1'h1;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic fire = 1'h0;
    logic reset_pin_n = 1'h1;
    logic por_n = 1'h1;
    logic other_rst_req = 1'h0;
    logic irq_any = 1'h0;
    logic [2:0] sel = 3'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, core_clk_en, periph_clk_en, tmr34_slow_clk_en, irq;
    logic fast_osc_24m_en, fast_osc_49m_en, reg_low_bias, power_nets_off, pin_hold;
    logic system_clk_tick;
    logic [4:0] osc;
    logic [5:0] evt;
    int num_errors = 0;
    int n_tests = 0;
    // Gates as one word: core periph tmr34 f24 f49 bias nets hold irq
    wire logic [8:0] outs = {core_clk_en, periph_clk_en, tmr34_slow_clk_en, fast_osc_24m_en,
        fast_osc_49m_en, reg_low_bias, power_nets_off, pin_hold, irq};

    pmc_top u_pmc_top (.clk, .rst_n, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .fast_osc_24m(osc[0]), .fast_osc_49m(osc[1]), .slow_osc_80k(osc[2]),
        .ext_rc_osc(osc[3]), .ext_cmos_clock(osc[4]), .reset_pin_n, .por_n, .other_rst_req,
        .irq_any, .timer4_evt(evt[0]), .serial_periph_port_act(evt[1]),
        .two_wire_target_port_act(evt[2]), .port_match_evt(evt[3]), .comp0_level(evt[4]),
        .config_logic_unit_evt(evt[5]), .core_clk_en, .periph_clk_en, .tmr34_slow_clk_en,
        .fast_osc_24m_en, .fast_osc_49m_en, .reg_low_bias, .power_nets_off, .pin_hold,
        .system_clk_tick, .irq);
    pmc_far_end u_pmc_far_end (.clk, .rst_n, .fire, .sel,
        .osc_en({fast_osc_49m_en, fast_osc_24m_en}), .osc, .evt);

    // 40 MHz
    initial begin
        forever #12.5 clk = ~clk;
    end
    // Run needs about 10k cycles; 40k is a hang
    initial begin
        #1ms;
        num_errors++;
        conclude();
    end

    task automatic conclude();
        $display("Compares %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // One bus transfer; request held until pready seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        do @(posedge clk); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'h0, a, 32'h0);
        `CHECK(nm, e, rd);
    endtask
    // Clocks spanned by two system ticks, after two to let a new setting settle
    task automatic span(output int n);
        longint t0;
        repeat (2) @(posedge system_clk_tick);
        t0 = $time;
        repeat (2) @(posedge system_clk_tick);
        n = int'(($time - t0) / 25);
    endtask
    // Bits: por, pin, other; held 4 clocks then given time to sync
    task automatic pulse_rst(input logic [2:0] b);
        other_rst_req <= b[0];
        reset_pin_n <= !b[1];
        por_n <= !b[2];
        repeat (4) @(posedge clk);
        other_rst_req <= 1'h0;
        reset_pin_n <= 1'h1;
        por_n <= 1'h1;
        repeat (6) @(posedge clk);
    endtask

    task automatic t_rst();
        int n;
        @(posedge clk);
        `CHECK("reset outs", 9'h1e0, outs);
        rchk("clk sel", OFS_CLK_SEL, 32'h030);
        rchk("mode", OFS_MODE, 32'h0);
        rchk("mask", OFS_IRQ_MASK, 32'h0);
        span(n);
        `CHECK("reset span", 32'h40, n);
        // Clock enable low must freeze the divider, so no tick may appear
        @(posedge clk);
        ce <= 1'h0;
        n = 0;
        repeat (99) begin
            @(posedge clk);
            n += int'(system_clk_tick !== 1'h0);
        end
        ce <= 1'h1;
        `CHECK("frozen ticks", 0, n);
        wr(8'h1c, 32'hffffffff);
        `CHECK("write slverr", 1'h1, err);
        rchk("unmapped", 8'h1c, 32'h0);
        wr(OFS_MODE, 32'h5);
        rchk("mode read only", OFS_MODE, 32'h0);
        $display("reset test done");
    endtask

    task automatic t_clk();
        int n;
        for (int s = 0; s < 5; s++) begin
            wr(OFS_CLK_SEL, 32'(s));
            span(n);
            `CHECK("source span", 8 + 4 * s, n);
            `CHECK("fast49 en", s == 1, fast_osc_49m_en);
        end
        wr(OFS_CLK_SEL, 32'h101);
        span(n);
        `CHECK("fast49 prescaled", 32'h12, n);
        for (int p = 0; p < 2; p++) begin
            for (int d = 0; d < 8; d++) begin
                wr(OFS_CLK_SEL, 32'(p * 256 + d * 16));
                span(n);
                `CHECK("div span", (p ? 12 : 8) << d, n);
            end
        end
        wr(OFS_CLK_SEL, 32'h030);
        $display("clock test done");
    endtask

    task automatic t_idle();
        for (int m = 1; m >= 0; m--) begin
            wr(OFS_IRQ_MASK, 32'(m));
            wr(OFS_PCTRL_A, 32'h1);
            repeat (2) @(posedge clk);
            `CHECK("idle outs", 9'h0e0, outs);
            rchk("idle mode", OFS_MODE, 32'h1);
            irq_any <= 1'h1;
            @(posedge clk);
            irq_any <= 1'h0;
            repeat (3) @(posedge clk);
            `CHECK("idle woken", 9'h1e0 | 9'(m), outs);
            rchk("idle status", OFS_IRQ_STAT, 32'h1);
            repeat (2) @(posedge clk);
            `CHECK("irq cleared", 1'h0, irq);
        end
        $display("idle test done");
    endtask

    task automatic t_sleep();
        for (int i = 0; i < 6; i++) begin
            wr(OFS_CLK_SEL, 32'h030);
            wr(OFS_PCTRL_B, 32'(1 << (i % 2)));
            repeat (2) @(posedge clk);
            `CHECK("sleep outs", (i % 2) ? 9'h048 : 9'h040, outs);
            rchk("sleep mode", OFS_MODE, 32'(2 + i % 2));
            sel <= 3'(i);
            fire <= 1'h1;
            @(posedge clk);
            fire <= 1'h0;
            for (int k = 0; k < 30 && core_clk_en !== 1'h1; k++) @(posedge clk);
            `CHECK("sleep woken", 9'h1e0, outs);
            rchk("sleep status", OFS_IRQ_STAT, 32'h2);
        end
        $display("sleep test done");
    endtask

    task automatic t_stop();
        for (int i = 0; i < 3; i++) begin
            wr(OFS_REG_CTRL, 32'(i > 0));
            wr(OFS_CLK_SEL, 32'h031);
            wr(OFS_PCTRL_A, 32'h2);
            repeat (2) @(posedge clk);
            `CHECK("held outs", 9'h006, outs);
            pulse_rst(3'h1);
            `CHECK("other reset", i ? 9'h006 : 9'h1e0, outs);
            pulse_rst(i == 1 ? 3'h2 : 3'h4);
            `CHECK("pin reset", 9'h1e0, outs);
            rchk("restored sel", OFS_CLK_SEL, 32'h030);
        end
        $display("stop test done");
    endtask

    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        t_rst();
        t_clk();
        t_idle();
        t_sleep();
        t_stop();
        conclude();
    end
endmodule

`default_nettype wire
